// [hw/sssc_pkg.sv]
// Shared constants and types for the synchronous serial port
package sssc_pkg;
  localparam int BRG_W = 8;
  localparam logic [7:0] OFF_BUF = 8'h00;
  localparam logic [7:0] OFF_CTL = 8'h04;
  localparam logic [7:0] OFF_COND = 8'h08;
  localparam logic [7:0] OFF_STS = 8'h0C;
  localparam logic [7:0] OFF_MSK = 8'h10;
  localparam logic [7:0] OFF_I2C = 8'h14;
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_EN = 5;
  localparam int CTL_CKP = 4;
  localparam int COND_SMP = 7;
  localparam int COND_CKE = 6;
  localparam int COND_BF = 0;
  localparam int I2C_GO = 7;
  localparam int STS_W = 3;
  localparam int STS_BYTE = 0;
  localparam int STS_STOP = 1;
  localparam int STS_COLL = 2;
  localparam logic [3:0] MODE_M4 = 4'h0;
  localparam logic [3:0] MODE_M16 = 4'h1;
  localparam logic [3:0] MODE_M64 = 4'h2;
  localparam logic [3:0] MODE_MBRG = 4'h3;
  localparam logic [3:0] MODE_SSS = 4'h4;
  localparam logic [3:0] MODE_SNOSS = 4'h5;
  localparam logic [3:0] MODE_I2CM = 4'h8;
  localparam logic [7:0] HALF_M4 = 8'h01;
  localparam logic [7:0] HALF_M16 = 8'h07;
  localparam logic [7:0] HALF_M64 = 8'h1F;
  localparam logic [3:0] BITS = 4'h8;
  localparam logic [3:0] MSB = 4'h7;
  localparam logic [7:0] CTL_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SDA_LOW = 3'b001,
    ST_SCL_REL = 3'b010,
    ST_SCL_HI = 3'b011,
    ST_SDA_REL = 3'b100
  } sssc_stop_st_t;
endpackage

// [hw/sssc_brg_if.sv]
// Link between the port core and its baud rate generator
interface sssc_brg_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] value;
  logic en;
  logic expired;
  modport ctl (output load, output value, output en, input expired);
  modport gen (input load, input value, input en, output expired);
endinterface

// [hw/sssc_baud_gen.sv]
// Reloading down counter used as baud rate generator
module sssc_baud_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  sssc_brg_if.gen brg
);
  logic [$bits(brg.value)-1:0] cnt_r;
  logic [$bits(brg.value)-1:0] cnt_nxt;

  assign brg.expired = brg.en & (cnt_r == '0);

  always_comb begin
    cnt_nxt = cnt_r;
    if (brg.load) begin
      cnt_nxt = brg.value;
    end else if (brg.en) begin
      cnt_nxt = (cnt_r == '0) ? brg.value : cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// [hw/sssc_top.sv]
// Synchronous serial port: SPI master/slave and I2C Stop with collision check
module sssc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sleep_i,
  input wire logic mod_clk_en_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic ss_n_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic wake_o
);
  sssc_brg_if #(.W(sssc_pkg::BRG_W)) brg ();
  sssc_baud_gen u_brg (.clk_i(clk_i), .rst_i(rst_i), .brg(brg));

  logic [7:0] ctl_r, ctl_nxt;
  logic smp_r, smp_nxt, cke_r, cke_nxt, bf_r, bf_nxt;
  logic [7:0] rbuf_r, rbuf_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
  logic busy_r, busy_nxt, half_r, half_nxt, sdo_r, sdo_nxt, sck_q_r;
  logic [3:0] cnt_r, cnt_nxt;
  logic [sssc_pkg::STS_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt, set_ev;
  logic [6:0] baud_r, baud_nxt;
  sssc_pkg::sssc_stop_st_t st_r, st_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic wr, rd, run_en, en, master, slave, i2c, slv_sel, act_e, ret_e;
  logic smp_e, shf_e, done, coll;
  logic [3:0] mode;

  assign mode = ctl_r[3:0];
  assign en = ctl_r[sssc_pkg::CTL_EN];
  assign master = en & (mode <= sssc_pkg::MODE_MBRG);
  assign slave = en & (mode == sssc_pkg::MODE_SSS || mode == sssc_pkg::MODE_SNOSS);
  assign i2c = en & (mode == sssc_pkg::MODE_I2CM);
  assign slv_sel = slave & (mode == sssc_pkg::MODE_SNOSS || !ss_n_i);
  // master logic advances only on powered module clock
  assign run_en = ~sleep_i & mod_clk_en_i;
  assign wr = cyc_i & stb_i & we_i & ~ack_r & sel_i[0];
  assign rd = cyc_i & stb_i & ~we_i & ~ack_r;
  assign act_e = (sck_q_r == ctl_r[sssc_pkg::CTL_CKP]) && (sck_i != ctl_r[sssc_pkg::CTL_CKP]);
  assign ret_e = (sck_q_r != ctl_r[sssc_pkg::CTL_CKP]) && (sck_i == ctl_r[sssc_pkg::CTL_CKP]);
  // edge select picks sampling versus shifting edge
  assign smp_e = cke_r ? act_e : ret_e;
  assign shf_e = cke_r ? ret_e : act_e;

  assign brg.en = run_en;
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign sdo_o = sdo_r;
  assign sdo_oe_o = master | slv_sel;
  // idle level, active half set by edge select
  assign sck_o = ctl_r[sssc_pkg::CTL_CKP] ^ (busy_r & (half_r ^ ~cke_r));
  assign sck_oe_o = master;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  // SDA held low through SCL release
  assign sda_oe_o = (st_r == sssc_pkg::ST_SDA_LOW) || (st_r == sssc_pkg::ST_SCL_REL)
                    || (st_r == sssc_pkg::ST_SCL_HI);
  assign scl_oe_o = (st_r == sssc_pkg::ST_SDA_LOW);
  // unmasked event drives interrupt and wake
  assign irq_o = |(sts_r & msk_r);
  assign wake_o = irq_o;

  always_comb begin
    ctl_nxt = ctl_r;
    smp_nxt = smp_r;
    cke_nxt = cke_r;
    bf_nxt = bf_r;
    rbuf_nxt = rbuf_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    busy_nxt = busy_r;
    half_nxt = half_r;
    sdo_nxt = sdo_r;
    cnt_nxt = cnt_r;
    sts_nxt = sts_r;
    msk_nxt = msk_r;
    baud_nxt = baud_r;
    st_nxt = st_r;
    ack_nxt = cyc_i & stb_i & ~ack_r;
    dat_nxt = '0;
    set_ev = '0;
    done = 1'b0;
    coll = 1'b0;
    brg.load = 1'b0;
    brg.value = {1'b0, baud_r};
    case (mode)
      sssc_pkg::MODE_M4: brg.value = sssc_pkg::HALF_M4;
      sssc_pkg::MODE_M16: brg.value = sssc_pkg::HALF_M16;
      sssc_pkg::MODE_M64: brg.value = sssc_pkg::HALF_M64;
      default: brg.value = {1'b0, baud_r};
    endcase
    if (rd) begin
      case (adr_i)
        sssc_pkg::OFF_BUF: begin
          dat_nxt[7:0] = rbuf_r;
          bf_nxt = 1'b0;
        end
        sssc_pkg::OFF_CTL: dat_nxt[7:0] = ctl_r;
        sssc_pkg::OFF_COND: begin
          dat_nxt[sssc_pkg::COND_SMP] = smp_r;
          dat_nxt[sssc_pkg::COND_CKE] = cke_r;
          dat_nxt[sssc_pkg::COND_BF] = bf_r;
        end
        sssc_pkg::OFF_STS: dat_nxt[sssc_pkg::STS_W-1:0] = sts_r;
        sssc_pkg::OFF_MSK: dat_nxt[sssc_pkg::STS_W-1:0] = msk_r;
        sssc_pkg::OFF_I2C: dat_nxt[7:0] = {st_r != sssc_pkg::ST_IDLE, baud_r};
        default: dat_nxt = '0;
      endcase
    end
    if (wr) begin
      case (adr_i)
        sssc_pkg::OFF_BUF: begin
          if (busy_r || cnt_r != '0) begin
            ctl_nxt[sssc_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            tx_nxt = dat_i[7:0];
            sdo_nxt = dat_i[7];
            if (master) begin
              busy_nxt = 1'b1;
              half_nxt = 1'b0;
              brg.load = 1'b1;
            end
          end
        end
        sssc_pkg::OFF_CTL: ctl_nxt = dat_i[7:0];
        sssc_pkg::OFF_COND: begin
          smp_nxt = dat_i[sssc_pkg::COND_SMP];
          cke_nxt = dat_i[sssc_pkg::COND_CKE];
        end
        sssc_pkg::OFF_STS: sts_nxt = sts_r & ~dat_i[sssc_pkg::STS_W-1:0];
        sssc_pkg::OFF_MSK: msk_nxt = dat_i[sssc_pkg::STS_W-1:0];
        sssc_pkg::OFF_I2C: begin
          baud_nxt = dat_i[6:0];
          if (dat_i[sssc_pkg::I2C_GO] && i2c && st_r == sssc_pkg::ST_IDLE) begin
            st_nxt = sssc_pkg::ST_SDA_LOW;
            brg.load = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // master frozen while module clock is halted
    if (master && busy_r && brg.expired) begin
      half_nxt = ~half_r;
      // sample at mid or end of bit
      if (half_r == smp_r) begin
        rx_nxt = {rx_r[6:0], sdi_i};
        cnt_nxt = cnt_r + 1'b1;
      end
      if (half_r) begin
        if (cnt_nxt == sssc_pkg::BITS) begin
          done = 1'b1;
          busy_nxt = 1'b0;
          cnt_nxt = '0;
        end else begin
          sdo_nxt = tx_r[3'(sssc_pkg::MSB - cnt_nxt)];
        end
      end
    end
    // slave shifts on external clock edges only
    if (slave && !slv_sel) begin
      cnt_nxt = '0;
    end else if (slave) begin
      if (smp_e) begin
        rx_nxt = {rx_r[6:0], sdi_i};
        cnt_nxt = cnt_r + 1'b1;
        // full byte completes the slave transfer
        if (cnt_nxt == sssc_pkg::BITS) begin
          done = 1'b1;
          cnt_nxt = '0;
        end
      end
      if (shf_e) begin
        sdo_nxt = tx_r[3'(sssc_pkg::MSB - cnt_r)];
      end
    end
    if (done) begin
      rbuf_nxt = rx_nxt;
      if (bf_r) begin
        ctl_nxt[sssc_pkg::CTL_OVF] = 1'b1;
      end
      bf_nxt = 1'b1;
      set_ev[sssc_pkg::STS_BYTE] = 1'b1;
    end
    if (run_en) begin
      unique case (st_r)
        sssc_pkg::ST_IDLE: ;
        // release SCL only after SDA seen low
        sssc_pkg::ST_SDA_LOW: begin
          if (brg.expired && !sda_i) begin
            st_nxt = sssc_pkg::ST_SCL_REL;
          end
        end
        // SCL high loads seven reload bits
        sssc_pkg::ST_SCL_REL: begin
          if (scl_i) begin
            st_nxt = sssc_pkg::ST_SCL_HI;
            brg.value = {1'b0, baud_r};
            brg.load = 1'b1;
          end
        end
        // SCL pulled low before SDA release
        sssc_pkg::ST_SCL_HI: begin
          if (!scl_i) begin
            coll = 1'b1;
          end else if (brg.expired) begin
            st_nxt = sssc_pkg::ST_SDA_REL;
            brg.value = {1'b0, baud_r};
            brg.load = 1'b1;
          end
        end
        // SDA low after release and expiry
        sssc_pkg::ST_SDA_REL: begin
          if (brg.expired) begin
            if (!sda_i) begin
              coll = 1'b1;
            end else begin
              st_nxt = sssc_pkg::ST_IDLE;
              set_ev[sssc_pkg::STS_STOP] = 1'b1;
            end
          end
        end
        default: st_nxt = sssc_pkg::ST_IDLE;
      endcase
    end
    if (coll) begin
      st_nxt = sssc_pkg::ST_IDLE;
      set_ev[sssc_pkg::STS_COLL] = 1'b1;
    end
    if (!en) begin
      busy_nxt = 1'b0;
      cnt_nxt = '0;
      st_nxt = sssc_pkg::ST_IDLE;
    end
    sts_nxt = sts_nxt | set_ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= sssc_pkg::CTL_RST;
      smp_r <= 1'b0;
      cke_r <= 1'b0;
      bf_r <= 1'b0;
      rbuf_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      busy_r <= 1'b0;
      half_r <= 1'b0;
      sdo_r <= 1'b0;
      cnt_r <= '0;
      sts_r <= '0;
      msk_r <= '0;
      baud_r <= '0;
      st_r <= sssc_pkg::ST_IDLE;
      ack_r <= 1'b0;
      dat_r <= '0;
      sck_q_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      smp_r <= smp_nxt;
      cke_r <= cke_nxt;
      bf_r <= bf_nxt;
      rbuf_r <= rbuf_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      busy_r <= busy_nxt;
      half_r <= half_nxt;
      sdo_r <= sdo_nxt;
      cnt_r <= cnt_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      baud_r <= baud_nxt;
      st_r <= st_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      sck_q_r <= sck_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sleep_freeze;
    sleep_i && busy_r |=> $stable(cnt_r) && $stable(half_r) && busy_r;
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("master moved in sleep");
  property p_wake;
    master && done && msk_r[sssc_pkg::STS_BYTE] |=> irq_o && wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after master byte");
  property p_clk_follow;
    busy_r && !mod_clk_en_i |=> $stable(sck_o);
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("sck moved without clock");
  property p_slave_shift;
    slv_sel && smp_e && cnt_r < sssc_pkg::MSB |=> cnt_r == $past(cnt_r) + 4'h1;
  endproperty
  a_slave_shift: assert property (p_slave_shift) else $error("slave missed edge");
  property p_slave_flag;
    slv_sel && smp_e && cnt_r == sssc_pkg::MSB |=> sts_r[sssc_pkg::STS_BYTE] && bf_r;
  endproperty
  a_slave_flag: assert property (p_slave_flag) else $error("slave byte not flagged");
  property p_reset;
    disable iff (1'b0) rst_i |=> !en && !busy_r && st_r == sssc_pkg::ST_IDLE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left port active");
  property p_idle_level;
    master && !busy_r |-> sck_o == ctl_r[sssc_pkg::CTL_CKP];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("wrong idle level");
  property p_sample_mid;
    busy_r && brg.expired && !half_r && !smp_r |=> cnt_r == $past(cnt_r) + 4'h1;
  endproperty
  a_sample_mid: assert property (p_sample_mid) else $error("mid sample missed");
  property p_coll_sda;
    run_en && st_r == sssc_pkg::ST_SDA_REL && brg.expired && !sda_i
      |=> sts_r[sssc_pkg::STS_COLL];
  endproperty
  a_coll_sda: assert property (p_coll_sda) else $error("SDA collision missed");
  property p_coll_scl;
    run_en && st_r == sssc_pkg::ST_SCL_HI && !scl_i |=> sts_r[sssc_pkg::STS_COLL];
  endproperty
  a_coll_scl: assert property (p_coll_scl) else $error("SCL collision missed");
  property p_sda_first;
    !scl_oe_o && st_r != sssc_pkg::ST_IDLE && st_r != sssc_pkg::ST_SDA_REL |-> sda_oe_o;
  endproperty
  a_sda_first: assert property (p_sda_first) else $error("SCL freed before SDA low");
  property p_brg_load;
    run_en && st_r == sssc_pkg::ST_SCL_REL && scl_i
      |-> brg.load && brg.value == {1'b0, baud_r};
  endproperty
  a_brg_load: assert property (p_brg_load) else $error("generator not reloaded");
  property p_release;
    coll |=> !sda_oe_o && !scl_oe_o ##1 !sda_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("lines held after collision");
  c_master_byte: cover property (master && done);
  c_slave_byte: cover property (slave && done);
  c_stop_ok: cover property (set_ev[sssc_pkg::STS_STOP]);
  c_stop_coll: cover property (coll);
endmodule

// [test/sssc_peer.sv]
// Far side model: open-drain I2C lines with pull-ups and an SPI echo peer
module sssc_peer (
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  input wire logic scl_hold_i,
  input wire logic sda_hold_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic scl_o,
  output logic sda_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign scl_o = ~(scl_oe_i | scl_hold_i);
  assign sda_o = ~(sda_oe_i | sda_hold_i);
  // Released data line shows the inverse
  assign sdi_o = sdo_oe_i ? sdo_i : ~sdo_i;
endmodule

// [test/sssc_top_test.sv]
// Register-level tests of the synchronous serial port
module sssc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slp = 0, mce = 1, slow = 0;
  logic sck = 0, ss_n = 1, sclh = 0, sdah = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o;
  logic ack_o, sck_o, sck_oe_o, sdi, sdo_o, sdo_oe_o, scl, scl_o, scl_oe_o;
  logic sda, sda_o, sda_oe_o, irq_o, wake_o;
  logic [7:0] q;
  int err_total = 0, n_checks = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) mce <= slow ? ~mce : 1'b1;
  sssc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_i(slp), .mod_clk_en_i(mce), .sck_i(sck), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .ss_n_i(ss_n), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o), .wake_o(wake_o));
  sssc_peer u_peer (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .scl_hold_i(sclh),
    .sda_hold_i(sdah), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .scl_o(scl), .sda_o(sda),
    .sdi_o(sdi));
  task end_sim;
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[7:0];
    if (n >= 50) chk(1'b0, 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wirq(input int lim);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task stop_run(input logic [7:0] st);
    wr(sssc_pkg::OFF_STS, 8'h07);
    wr(sssc_pkg::OFF_CTL, 8'h28);
    wr(sssc_pkg::OFF_I2C, 8'h90);
    if (st == 8'h04 && sdah === 1'b0) begin
      wt(1);
      while (scl_oe_o !== 1'b0) wt(1);
      wt(2);
      sclh <= 1;
    end
    wirq(2000);
    wt(2);
    chk({scl_oe_o, sda_oe_o}, 8'h00); // lines released
    rdc(sssc_pkg::OFF_STS, st); // stop outcome
    sclh <= 0;
    sdah <= 0;
  endtask
  logic [1:0] md [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
  initial begin
    wt(10);
    rst_i <= 0;
    rdc(sssc_pkg::OFF_CTL, sssc_pkg::CTL_RST); // reset value
    rdc(8'h30, 8'h00);
    chk({irq_o, sck_oe_o, sda_oe_o, scl_oe_o}, 8'h00); // outputs idle
    wr(sssc_pkg::OFF_MSK, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(sssc_pkg::OFF_COND, {i[0], md[i][0], 6'h00});
      wr(sssc_pkg::OFF_CTL, {3'b001, md[i][1], sssc_pkg::MODE_M4});
      wt(2);
      chk(sck_o, md[i][1]); // idle level
      wr(sssc_pkg::OFF_BUF, 8'hA5 ^ i[7:0]);
      chk({md[i][1] ^ !md[i][0]}, sck_o); // first half level
      wr(sssc_pkg::OFF_BUF, 8'h00);
      wirq(500);
      chk(wake_o, 1'b1); // wake on completion
      chk(sck_o, md[i][1]); // clock back to idle
      rdc(sssc_pkg::OFF_CTL, {3'b101, md[i][1], 4'h0}); // Write collision set
      rdc(sssc_pkg::OFF_BUF, 8'hA5 ^ i[7:0]); // echoed byte
      wr(sssc_pkg::OFF_STS, 8'h01);
      wt(1);
      chk(irq_o, 1'b0); // cleared event
    end
    wr(sssc_pkg::OFF_MSK, 8'h00);
    wr(sssc_pkg::OFF_BUF, 8'h5A);
    wt(60);
    chk(irq_o, 1'b0); // masked event
    rdc(sssc_pkg::OFF_STS, 8'h01); // event recorded
    wr(sssc_pkg::OFF_STS, 8'h01);
    wr(sssc_pkg::OFF_MSK, 8'h07);
    slow <= 1;
    wr(sssc_pkg::OFF_BUF, 8'h96);
    wt(40);
    chk(irq_o, 1'b0); // slower module clock
    wirq(500);
    chk(irq_o, 1'b1); // completes later
    slow <= 0;
    wr(sssc_pkg::OFF_STS, 8'h01);
    wr(sssc_pkg::OFF_BUF, 8'h69);
    wt(6);
    slp <= 1;
    wt(200);
    chk(irq_o, 1'b0); // frozen in sleep
    slp <= 0;
    wirq(500);
    rdc(sssc_pkg::OFF_BUF, 8'h69); // resumed intact
    wr(sssc_pkg::OFF_STS, 8'h01);
    wr(sssc_pkg::OFF_BUF, 8'h33);
    wt(8);
    rst_i <= 1;
    wt(2);
    rst_i <= 0;
    chk({sck_oe_o, irq_o}, 8'h00); // transfer aborted
    rdc(sssc_pkg::OFF_CTL, 8'h00); // port disabled
    wr(sssc_pkg::OFF_MSK, 8'h07);
    wr(sssc_pkg::OFF_COND, 8'h40);
    wr(sssc_pkg::OFF_CTL, {4'h2, sssc_pkg::MODE_SSS});
    wr(sssc_pkg::OFF_BUF, 8'h3C);
    slp <= 1;
    ss_n <= 0;
    for (int b = 0; b < 16; b++) begin
      wt(4);
      sck <= ~sck;
    end
    wt(6);
    chk({irq_o, wake_o}, 8'h03); // byte in sleep
    slp <= 0;
    ss_n <= 1;
    rdc(sssc_pkg::OFF_BUF, 8'h3C); // received byte
    rdc(sssc_pkg::OFF_STS, 8'h01); // byte flag
    stop_run(8'h02); // clean stop
    sdah <= 1;
    stop_run(8'h04); // data held low
    stop_run(8'h04); // clock pulled low
    end_sim;
  end
  initial begin
    wt(60000);
    err_total++;
    end_sim;
  end
endmodule
